// ===== ssc_checker.sv
// Checker for the synchronous serial channel top module.
// Assumes it is bound to ssc_sync_serial and sees only its ports.
`timescale 1ns/1ps
module ssc_checker
   import ssc_pkg::*;
(
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic [15:0] avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        serialClockOut,
   input wire logic        serialClockOe,
   input wire logic        transferDoneRequest
);
   // ----------------------------------------------------------------
   // Shadow of the control register
   // ----------------------------------------------------------------
   logic [7:0] ctl;
   logic       wAcc;
   logic       rAcc;
   assign wAcc = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign rAcc = avs_read && !avs_waitrequest;
   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctl <= SSC_CONTROL_RESET;
      end else if (wAcc && avs_address == SSC_IDX_CONTROL) begin
         ctl <= avs_writedata[7:0] & SSC_CONTROL_MASK;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
      |=> !avs_waitrequest) else $error("wait longer than one cycle");
   a_wait_idle: assert property (!(avs_read || avs_write)
      |-> !avs_waitrequest) else $error("wait without request");
   a_status_fixed: assert property (
      rAcc && avs_address == SSC_IDX_STATUS |-> avs_readdata[31:8] == 0
      && avs_readdata[7] && avs_readdata[4:2] == 3'h0)
      else $error("status fixed bits wrong");
   a_control_read: assert property (
      rAcc && avs_address == SSC_IDX_CONTROL |-> avs_readdata == {24'h0, ctl})
      else $error("control readback wrong");
   a_pin_dir: assert property (!$changed(ctl)
      |-> serialClockOe == !ctl[SSC_CTL_CLKSRC]) else $error("clock pin dir");
   a_done_pulse: assert property (transferDoneRequest
      |=> !transferDoneRequest) else $error("done pulse too long");
   a_idle_after: assert property (
      transferDoneRequest && !ctl[SSC_CTL_CLKSRC] |-> serialClockOut
      ##1 $stable(serialClockOut)[*8]) else $error("clock runs after done");
   a_abort_quiet: assert property (
      wAcc && avs_address == SSC_IDX_CONTROL |=> !transferDoneRequest[*8])
      else $error("done after abort");
   a_cont_run: assert property (
      ctl[7:6] == SSC_MODE_CONT && !ctl[SSC_CTL_CLKSRC] && !wAcc
      |-> !transferDoneRequest ##[1:520] $changed(serialClockOut))
      else $error("continuous clock stalled");
endmodule

bind ssc_sync_serial ssc_checker i_chk (
   .clk                 (clk),
   .resetn              (resetn),
   .avs_address         (avs_address),
   .avs_read            (avs_read),
   .avs_write           (avs_write),
   .avs_writedata       (avs_writedata),
   .avs_byteenable      (avs_byteenable),
   .avs_readdata        (avs_readdata),
   .avs_waitrequest     (avs_waitrequest),
   .serialClockOut      (serialClockOut),
   .serialClockOe       (serialClockOe),
   .transferDoneRequest (transferDoneRequest)
);

// ===== ssc_edge_detect.sv
// Edge detector for the serial clock pin when it is an input.
// Assumes the pin level is already synchronous to clk.
`timescale 1ns/1ps
module ssc_edge_detect (
   input  wire logic clk,
   input  wire logic resetn,
   input  wire logic level,
   output logic      rise,
   output logic      fall
);

   logic prevLevel;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         prevLevel <= 1'b1;
      end else begin
         prevLevel <= level;
      end
   end

   assign rise = level & ~prevLevel;
   assign fall = ~level & prevLevel;

endmodule

// ===== ssc_peer.sv
// Far-side serial peer: shifts a word out and captures the data line.
// Assumes the resolved clock pin level drives sck.
`timescale 1ns/1ps
module ssc_peer (
   input  wire logic        clk,
   input  wire logic        sck,
   input  wire logic        dOut,
   output logic             dIn,
   output logic             extClk,
   output logic [15:0]      rxWord
);
   logic [15:0] txSh;
   initial begin
      dIn = 1'b0;
      extClk = 1'b1;
      txSh = 16'h0000;
      rxWord = 16'h0000;
   end
   task load(input logic [15:0] w);
      txSh = w;
      rxWord = 16'h0000;
   endtask
   // Bit changes on the falling edge, LSB first
   always @(negedge sck) begin
      dIn <= txSh[0];
      txSh <= {~txSh[0], txSh[15:1]};
   end
   always @(posedge sck) begin
      rxWord <= {dOut, rxWord[15:1]};
   end
   // External clock, idles high between pulses
   task pulses(input int n, input int half);
      repeat (n) begin
         repeat (half) @(posedge clk);
         extClk <= 1'b0;
         repeat (half) @(posedge clk);
         extClk <= 1'b1;
      end
   endtask
endmodule

// ===== ssc_pkg.sv
// Constants shared by the synchronous serial channel files.
// Assumes a 40 MHz system clock and a word-addressed Avalon-MM slave port.
package ssc_pkg;

   // -------------------------------------------------------------------
   // Register word indices (slave address = index)
   // -------------------------------------------------------------------
   localparam logic [15:0] SSC_IDX_CONTROL = 16'hFFA0;
   localparam logic [15:0] SSC_IDX_STATUS  = 16'hFFA1;
   localparam logic [15:0] SSC_IDX_UPPER   = 16'hFFA2;
   localparam logic [15:0] SSC_IDX_LOWER   = 16'hFFA3;

   // -------------------------------------------------------------------
   // Control register fields
   // -------------------------------------------------------------------
   localparam int SSC_CTL_OPMODE_HI = 7;
   localparam int SSC_CTL_OPMODE_LO = 6;
   localparam int SSC_CTL_CLKSRC    = 3;
   localparam int SSC_CTL_DIV_HI    = 2;
   localparam int SSC_CTL_DIV_LO    = 0;
   localparam logic [7:0] SSC_CONTROL_RESET = 8'h00;
   localparam logic [7:0] SSC_CONTROL_MASK  = 8'hCF;

   // -------------------------------------------------------------------
   // Status register fields
   // -------------------------------------------------------------------
   localparam int SSC_STS_FIXED_ONE = 7;
   localparam int SSC_STS_OUTLEVEL  = 6;
   localparam int SSC_STS_OVERRUN   = 5;
   localparam int SSC_STS_SPARE     = 1;
   localparam int SSC_STS_START     = 0;
   localparam logic [7:0] SSC_STATUS_RESET = 8'h80;

   // -------------------------------------------------------------------
   // Operating modes and word lengths
   // -------------------------------------------------------------------
   localparam logic [1:0] SSC_MODE_8BIT  = 2'h0;
   localparam logic [1:0] SSC_MODE_16BIT = 2'h1;
   localparam logic [1:0] SSC_MODE_CONT  = 2'h2;
   localparam logic [4:0] SSC_LEN_8      = 5'h08;
   localparam logic [4:0] SSC_LEN_16     = 5'h10;

   // -------------------------------------------------------------------
   // Prescaler
   // -------------------------------------------------------------------
   localparam int SSC_PRESCALE_BITS = 9;

   typedef enum logic [1:0] {
      SSC_BUS_IDLE,
      SSC_BUS_ANSWER
   } ssc_bus_state_t;

endpackage

// ===== ssc_prescaler.sv
// Free-running prescaler giving half-period ticks of the serial clock.
// Assumes the divider code comes straight from the control register.
`timescale 1ns/1ps
module ssc_prescaler
   import ssc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic [2:0] divCode,
   output logic            halfTick
);

   logic [SSC_PRESCALE_BITS-1:0] count;
   logic [SSC_PRESCALE_BITS-1:0] tapMask;

   // -------------------------------------------------------------------
   // Tap select: half period of 512,128,32,16,8,4,2,1 clocks
   // -------------------------------------------------------------------
   always_comb begin
      case (divCode)
         3'h0:    tapMask = 9'h1FF;
         3'h1:    tapMask = 9'h07F;
         3'h2:    tapMask = 9'h01F;
         3'h3:    tapMask = 9'h00F;
         3'h4:    tapMask = 9'h007;
         3'h5:    tapMask = 9'h003;
         3'h6:    tapMask = 9'h001;
         default: tapMask = 9'h000;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         count <= '0;
      end else begin
         count <= count + 9'h001;
      end
   end

   assign halfTick = ((count & tapMask) == tapMask);

endmodule

// ===== ssc_sync_serial.sv
// Synchronous serial channel: 8/16-bit LSB-first shifter with registers.
// Assumes a 40 MHz clk, synchronous pins and a word-addressed Avalon slave.
//
// What this block does
// - Mode field picks 8-bit, 16-bit or continuous clock output.
// - Any control register write aborts a running transfer.
// - Clock source 0 drives the clock pin; 1 takes an external clock.
// - Divider codes 000..111 give clk/1024,256,64,32,16,8,4,2.
// - Control register resets to 0x00.
// - Status register resets to 0x80; bit 7 reads one always.
// - Status bits 4..2 read zero and ignore writes.
// - Output level write sets data-out while stopped; read returns data-out level.
// - Data-out keeps last bit; level write holds until next start.
// - External clock pulse after transfer completion sets overrun flag.
// - Overrun clears by writing zero; writing one is ignored.
// - Start flag write one starts in 8/16-bit modes, reads one while busy, self-clears.
// - Three pins: two-way clock, data input, data output.
// - LSB first; drive on falling edge, sample on rising edge.
// - Upper byte holds high half in 16-bit mode; 8-bit uses lower.
// - Each completed transfer pulses the transfer-done request.
// - Internal clock pulses during a transfer with clock source 0 or in continuous mode, idle otherwise.
//
// Design decision made here: the Avalon-MM slave port.
`timescale 1ns/1ps
module ssc_sync_serial
   import ssc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   // Avalon-MM slave
   input  wire logic [15:0] avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Serial pins
   input  wire logic        serialClockIn,
   output logic             serialClockOut,
   output logic             serialClockOe,
   input  wire logic        dataIn,
   output logic             dataOut,
   // Completion event
   output logic             transferDoneRequest
);

   // -------------------------------------------------------------------
   // Registers and state
   // -------------------------------------------------------------------
   logic [7:0]     serialControl;
   logic           overrunFlag;
   logic           busy;
   logic [15:0]    shiftData;
   logic [4:0]     bitCount;
   logic           clockLevel;
   ssc_bus_state_t busState;

   logic           accept;
   logic           wrEnable;
   logic           wrControl;
   logic           wrStatus;
   logic           wrUpper;
   logic           wrLower;
   logic [7:0]     wrByte;
   logic [1:0]     opMode;
   logic           externalClock;
   logic           halfTick;
   logic           extRise;
   logic           extFall;
   logic           serialRise;
   logic           serialFall;
   logic           startReq;
   logic           lastBit;
   logic [4:0]     wordLength;
   logic [7:0]     statusValue;

   // -------------------------------------------------------------------
   // Clock sources
   // -------------------------------------------------------------------
   ssc_prescaler u_prescaler (
      .clk      (clk),
      .resetn   (resetn),
      .divCode  (serialControl[SSC_CTL_DIV_HI:SSC_CTL_DIV_LO]),
      .halfTick (halfTick)
   );

   ssc_edge_detect u_edge (
      .clk    (clk),
      .resetn (resetn),
      .level  (serialClockIn),
      .rise   (extRise),
      .fall   (extFall)
   );

   assign opMode        = serialControl[SSC_CTL_OPMODE_HI:SSC_CTL_OPMODE_LO];
   assign externalClock = serialControl[SSC_CTL_CLKSRC];
   assign wordLength    = (opMode == SSC_MODE_16BIT) ? SSC_LEN_16 : SSC_LEN_8;

   // Internal edges come from the prescaler while the line is toggling
   assign serialRise = externalClock ? extRise : (halfTick & ~clockLevel);
   assign serialFall = externalClock ? extFall : (halfTick & clockLevel);

   // -------------------------------------------------------------------
   // Avalon slave: one wait state, answer in the second cycle
   // -------------------------------------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) &
                            (busState != SSC_BUS_ANSWER);
   assign accept   = (busState == SSC_BUS_ANSWER);
   assign wrEnable = accept & avs_write & avs_byteenable[0];
   assign wrByte   = avs_writedata[7:0];

   always_comb begin
      wrControl = 1'b0;
      wrStatus  = 1'b0;
      wrUpper   = 1'b0;
      wrLower   = 1'b0;
      if (avs_address == SSC_IDX_CONTROL) begin
         wrControl = wrEnable;
      end else if (avs_address == SSC_IDX_STATUS) begin
         wrStatus = wrEnable;
      end else if (avs_address == SSC_IDX_UPPER) begin
         wrUpper = wrEnable;
      end else if (avs_address == SSC_IDX_LOWER) begin
         wrLower = wrEnable;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         busState <= SSC_BUS_IDLE;
      end else begin
         case (busState)
            SSC_BUS_IDLE: begin
               if (avs_read | avs_write) begin
                  busState <= SSC_BUS_ANSWER;
               end
            end
            default: begin
               busState <= SSC_BUS_IDLE;
            end
         endcase
      end
   end

   // Status image: fixed one, pin level, overrun, zeros, start flag
   always_comb begin
      statusValue = 8'h00;
      statusValue[SSC_STS_FIXED_ONE] = 1'b1;
      statusValue[SSC_STS_OUTLEVEL]  = dataOut;
      statusValue[SSC_STS_OVERRUN]   = overrunFlag;
      statusValue[SSC_STS_START]     = busy;
   end

   // Read data captured the cycle before the answer
   always_ff @(posedge clk) begin
      if (!resetn) begin
         avs_readdata <= 32'h0000_0000;
      end else if (avs_read && busState == SSC_BUS_IDLE) begin
         if (avs_address == SSC_IDX_CONTROL) begin
            avs_readdata <= {24'h000000, serialControl};
         end else if (avs_address == SSC_IDX_STATUS) begin
            avs_readdata <= {24'h000000, statusValue};
         end else if (avs_address == SSC_IDX_UPPER) begin
            avs_readdata <= {24'h000000, shiftData[15:8]};
         end else if (avs_address == SSC_IDX_LOWER) begin
            avs_readdata <= {24'h000000, shiftData[7:0]};
         end else begin
            avs_readdata <= 32'h0000_0000;
         end
      end
   end

   // -------------------------------------------------------------------
   // Control register
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         serialControl <= SSC_CONTROL_RESET;
      end else if (wrControl) begin
         serialControl <= wrByte & SSC_CONTROL_MASK;
      end
   end

   // -------------------------------------------------------------------
   // Transfer sequencing
   // -------------------------------------------------------------------
   assign startReq = wrStatus & wrByte[SSC_STS_START] &
                     ~opMode[1];
   assign lastBit  = busy & serialRise & (bitCount == wordLength - 5'h01);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         busy     <= 1'b0;
         bitCount <= 5'h00;
      end else if (wrControl) begin
         busy     <= 1'b0;
         bitCount <= 5'h00;
      end else if (startReq && !busy) begin
         busy     <= 1'b1;
         bitCount <= 5'h00;
      end else if (lastBit) begin
         busy     <= 1'b0;
         bitCount <= 5'h00;
      end else if (busy && serialRise) begin
         bitCount <= bitCount + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         transferDoneRequest <= 1'b0;
      end else begin
         transferDoneRequest <= lastBit & ~wrControl;
      end
   end

   // -------------------------------------------------------------------
   // Internal clock line
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         clockLevel <= 1'b1;
      end else if (wrControl) begin
         clockLevel <= 1'b1;
      end else if (opMode == SSC_MODE_CONT) begin
         if (halfTick) begin
            clockLevel <= ~clockLevel;
         end
      end else if (busy && halfTick && !externalClock) begin
         clockLevel <= ~clockLevel;
      end else if (!busy) begin
         clockLevel <= 1'b1;
      end
   end

   assign serialClockOut = clockLevel;
   assign serialClockOe  = ~externalClock;

   // -------------------------------------------------------------------
   // Data shifter: upper byte is bits 15:8, lower byte bits 7:0
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         shiftData <= 16'h0000;
      end else if (busy && serialRise && !wrControl) begin
         if (opMode == SSC_MODE_16BIT) begin
            shiftData <= {dataIn, shiftData[15:1]};
         end else begin
            shiftData <= {shiftData[15:8], dataIn,
                          shiftData[7:1]};
         end
      end else begin
         if (wrUpper) begin
            shiftData[15:8] <= wrByte;
         end
         if (wrLower) begin
            shiftData[7:0] <= wrByte;
         end
      end
   end

   // -------------------------------------------------------------------
   // Data-out pin: level bit while stopped, shifter bit on falling edges
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         dataOut <= 1'b0;
      end else if (busy && serialFall && !wrControl) begin
         dataOut <= shiftData[0];
      end else if (wrStatus && !busy) begin
         dataOut <= wrByte[SSC_STS_OUTLEVEL];
      end
   end

   // -------------------------------------------------------------------
   // Overrun flag: set wins over a clearing write
   // -------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!resetn) begin
         overrunFlag <= SSC_STATUS_RESET[SSC_STS_OVERRUN];
      end else if (externalClock && !busy && extRise &&
                   !opMode[1]) begin
         overrunFlag <= 1'b1;
      end else if (wrStatus && !wrByte[SSC_STS_OVERRUN]) begin
         overrunFlag <= 1'b0;
      end
   end

endmodule

// ===== tb.sv
// Self-checking bench for the synchronous serial channel.
// Assumes the bound checker and the serial peer model.
`timescale 1ns/1ps
module tb
   import ssc_pkg::*;
;
   localparam int HALF [8] = '{512, 128, 32, 16, 8, 4, 2, 1};
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [15:0] avs_address = 16'h0000;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  avs_byteenable = 4'h0;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        serialClockOut;
   logic        serialClockOe;
   logic        dataIn;
   logic        dataOut;
   logic        transferDoneRequest;
   logic        extClk;
   logic        sckLine;
   logic        prevSck = 1'b1;
   logic        prevOut = 1'b1;
   logic [15:0] rxWord;
   logic [7:0]  q;
   int          err_count = 0;
   int          cmp_count = 0;
   int          riseCnt = 0;
   int          doneCnt = 0;
   int          run = 0;
   int          lastHalf = 0;
   int          cyc = 0;
   int          i;
   assign sckLine = serialClockOe ? serialClockOut : extClk;
   always #12.5 clk = ~clk;
   ssc_sync_serial i_dut (.clk(clk), .resetn(resetn),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .serialClockIn(sckLine),
      .serialClockOut(serialClockOut), .serialClockOe(serialClockOe),
      .dataIn(dataIn), .dataOut(dataOut),
      .transferDoneRequest(transferDoneRequest));
   ssc_peer i_peer (.clk(clk), .sck(sckLine), .dOut(dataOut),
      .dIn(dataIn), .extClk(extClk), .rxWord(rxWord));
   // ----------------------------------------------------------------
   // Monitors and timeout
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      cyc <= cyc + 1;
      prevSck <= sckLine;
      prevOut <= serialClockOut;
      if (sckLine && !prevSck)
         riseCnt <= riseCnt + 1;
      if (transferDoneRequest)
         doneCnt <= doneCnt + 1;
      if (serialClockOut !== prevOut) begin
         lastHalf <= run;
         run <= 1;
      end else
         run <= run + 1;
      if (cyc == 60000) begin
         err_count++;
         close_out;
      end
   end
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   task close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h", $time, m, got);
      end
   endtask
   task bus(input logic r, input logic [15:0] a, input logic [7:0] d,
            input logic [3:0] be);
      int n;
      @(posedge clk);
      avs_read <= r;
      avs_write <= !r;
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_byteenable <= be;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      chk(n < 64, 1'b1, "bus timeout");
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      #1;
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      bus(1'b0, a, d, 4'h1);
   endtask
   task rd(input logic [15:0] a);
      bus(1'b1, a, 8'h00, 4'hF);
   endtask
   task wait_done;
      int n;
      n = 0;
      while (transferDoneRequest !== 1'b1 && n < 30000) begin
         @(posedge clk);
         n++;
      end
      #1;
      chk(n < 30000, 1'b1, "no done");
   endtask
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task t_regs;
      chk({serialClockOut, serialClockOe, dataOut}, 3'h6, "pins");
      rd(SSC_IDX_CONTROL);
      chk(q, 8'h00, "ctl reset");
      rd(SSC_IDX_STATUS);
      chk(q, 8'h80, "sts reset");
      bus(1'b0, SSC_IDX_CONTROL, 8'h43, 4'h0);
      wr(16'hFFA4, 8'h55);
      rd(16'hFFA4);
      chk(q, 8'h00, "unmapped");
      rd(SSC_IDX_CONTROL);
      chk(q, 8'h00, "byteenable");
      wr(SSC_IDX_CONTROL, 8'h43);
      rd(SSC_IDX_CONTROL);
      chk(q, 8'h43, "ctl rw");
      wr(SSC_IDX_STATUS, 8'hFE);
      rd(SSC_IDX_STATUS);
      chk(q, 8'hC0, "sts ro");
      chk(dataOut, 1'b1, "level hi");
      wr(SSC_IDX_STATUS, 8'h00);
      chk(dataOut, 1'b0, "level lo");
   endtask
   task t_xfer8(input logic [2:0] c);
      logic [7:0] d;
      logic [7:0] nd;
      d = 8'h5A ^ {c, 5'h00};
      nd = ~d;
      wr(SSC_IDX_CONTROL, {5'h00, c});
      wr(SSC_IDX_LOWER, d);
      i_peer.load({8'h00, nd});
      wr(SSC_IDX_STATUS, 8'h40);
      chk(dataOut, 1'b1, "level set");
      riseCnt = 0;
      wr(SSC_IDX_STATUS, 8'h01);
      wait_done;
      chk(riseCnt, 8, "rises 8");
      chk(lastHalf, HALF[c], "half period");
      chk(rxWord[15:8], d, "sent");
      chk(dataOut, d[7], "last bit");
      rd(SSC_IDX_LOWER);
      chk(q, nd, "received");
      rd(SSC_IDX_STATUS);
      chk(q, {1'b1, d[7], 6'h00}, "sts after");
      repeat (40) @(posedge clk);
      chk(riseCnt, 8, "idle clock");
   endtask
   task t_xfer16;
      wr(SSC_IDX_CONTROL, 8'h47);
      wr(SSC_IDX_UPPER, 8'hC3);
      wr(SSC_IDX_LOWER, 8'h81);
      i_peer.load(16'h1E2D);
      riseCnt = 0;
      wr(SSC_IDX_STATUS, 8'h01);
      wait_done;
      chk(riseCnt, 16, "rises 16");
      chk(rxWord, 16'hC381, "sent 16");
      rd(SSC_IDX_UPPER);
      chk(q, 8'h1E, "upper");
      rd(SSC_IDX_LOWER);
      chk(q, 8'h2D, "lower");
   endtask
   task t_abort;
      int k;
      int kd;
      wr(SSC_IDX_CONTROL, 8'h45);
      wr(SSC_IDX_STATUS, 8'h01);
      repeat (30) @(posedge clk);
      wr(SSC_IDX_CONTROL, 8'h45);
      // Let the abort's return of the clock to idle be counted first
      @(posedge clk);
      #1;
      k = riseCnt;
      kd = doneCnt;
      repeat (200) @(posedge clk);
      chk(riseCnt, k, "abort clock");
      chk(doneCnt, kd, "abort done");
      rd(SSC_IDX_STATUS);
      chk(q[0], 1'b0, "abort start");
   endtask
   task t_ext;
      wr(SSC_IDX_CONTROL, 8'h08);
      wr(SSC_IDX_LOWER, 8'h69);
      chk(serialClockOe, 1'b0, "pin input");
      i_peer.load(16'h00B4);
      wr(SSC_IDX_STATUS, 8'h01);
      i_peer.pulses(8, 4);
      wait_done;
      chk(rxWord[15:8], 8'h69, "ext sent");
      rd(SSC_IDX_LOWER);
      chk(q, 8'hB4, "ext rx");
      rd(SSC_IDX_STATUS);
      chk(q, 8'h80, "no overrun");
      i_peer.pulses(1, 4);
      repeat (4) @(posedge clk);
      rd(SSC_IDX_STATUS);
      chk(q, 8'hA0, "overrun");
      wr(SSC_IDX_STATUS, 8'h20);
      rd(SSC_IDX_STATUS);
      chk(q, 8'hA0, "overrun one");
      wr(SSC_IDX_STATUS, 8'h00);
      rd(SSC_IDX_STATUS);
      chk(q, 8'h80, "overrun clr");
   endtask
   task t_cont;
      int kd;
      wr(SSC_IDX_CONTROL, 8'h87);
      kd = doneCnt;
      riseCnt = 0;
      wr(SSC_IDX_STATUS, 8'h01);
      repeat (40) @(posedge clk);
      chk(riseCnt >= 16, 1'b1, "cont clock");
      chk(doneCnt, kd, "cont done");
      rd(SSC_IDX_STATUS);
      chk(q[0], 1'b0, "cont start");
      wr(SSC_IDX_CONTROL, 8'h00);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      resetn <= 1'b1;
      t_regs;
      for (i = 0; i < 8; i++)
         t_xfer8(i[2:0]);
      t_xfer16;
      t_abort;
      t_ext;
      t_cont;
      close_out;
   end
endmodule
